// file: hdl/smcb_cfg.svh
`ifndef SMCB_CFG_SVH
`define SMCB_CFG_SVH
// register offsets
`define SMCB_OFS_SYNTH_OFFSET 6'h0C
`define SMCB_OFS_CARRIER_HIGH 6'h0D
`define SMCB_OFS_CARRIER_MID  6'h0E
`define SMCB_OFS_CARRIER_LOW  6'h0F
`define SMCB_OFS_RATE_EXP     6'h10
`define SMCB_OFS_RATE_MANT    6'h11
`define SMCB_OFS_FORMAT       6'h12
// reset values
`define SMCB_RST_SYNTH_OFFSET 8'h00
`define SMCB_RST_CARRIER_HIGH 8'h1E
`define SMCB_RST_CARRIER_MID  8'hC4
`define SMCB_RST_CARRIER_LOW  8'hEC
`define SMCB_RST_RATE_EXP     8'h8C
`define SMCB_RST_RATE_MANT    8'h22
`define SMCB_RST_FORMAT       8'h02
// field positions
`define SMCB_CARRIER_HIGH_MASK 8'h3F
`define SMCB_MANCH_BIT        3
`define SMCB_MOD_LSB          4
`define SMCB_SRC_ASYNC        2'h3
// scaling: offset step is carrier step times 4 (2^16 / 2^14)
`define SMCB_OFFSET_SHIFT     2
`define SMCB_RATE_IMPLIED     9'h100
`endif

// file: hdl/smcb_pkg.sv
package smcb_pkg;
  typedef enum logic [2:0] {
    SMCB_MOD_2FSK, SMCB_MOD_GFSK, SMCB_MOD_OOK, SMCB_MOD_4FSK, SMCB_MOD_RSVD
  } smcb_mod_t;
  typedef enum logic [1:0] {
    SMCB_SYNC_NONE, SMCB_SYNC_16, SMCB_SYNC_32, SMCB_SYNC_RSVD
  } smcb_sync_t;
  typedef enum logic [1:0] {SMCB_SPI_CMD, SMCB_SPI_DATA} smcb_spi_t;
endpackage

// file: hdl/smcb_sync2.sv
`timescale 1ns/1ns
// two-stage synchroniser for pin inputs
module smcb_sync2 #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  // refuse an empty synchroniser
  if (W < 1) begin : gen_bad_width
    $error("synchroniser width must be at least one");
  end
  // first stage only feeds second
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// file: hdl/smcb_bank.sv
`timescale 1ns/1ns
`include "smcb_cfg.svh"
// Operation
// - signed 8-bit offset, scaled by four, added to carrier word for synthesizer
// - carrier word bits 23:22 read zero and ignore writes
// - carrier word assembled from high, middle, low byte registers
// - symbol rate uses 9-bit mantissa with implied one and 4-bit exponent
// - rate increment equals (256+mantissa) shifted by exponent per 2^28
// - exponent in low nibble of exponent register, mantissa full byte
// - modulation codes 000,001,011,100 decode; others flagged reserved
// - bit 3 enables Manchester; suppressed with 4-FSK or when asynchronous source selected
// - sync codes 000 none, 001 16-bit, 011 32-bit; others reserved
// - source 11 takes data from synchronised output pin zero
module smcb_bank (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        spi_csn_n,
  input  wire logic        spi_sclk,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  output logic             spi_miso_oe,
  input  wire logic [1:0]  tx_data_source,
  input  wire logic        general_output_pin_zero,
  input  wire logic        fifo_tx_bit,
  output logic [23:0]      synth_word,
  output logic [23:0]      base_carrier_word,
  output logic [27:0]      symbol_rate_step,
  output logic [3:0]       symbol_rate_exponent,
  output logic [7:0]       symbol_rate_mantissa,
  output smcb_pkg::smcb_mod_t  modulation_select,
  output smcb_pkg::smcb_sync_t sync_length,
  output logic             manchester_on,
  output logic             tx_bit,
  output logic             cfg_reserved
);
  // pin synchronisers
  logic [3:0] pin_s;
  smcb_sync2 #(.W(4)) smcb_sync2_inst (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in ({spi_csn_n, spi_sclk, spi_mosi, general_output_pin_zero}),
    .sync_out (pin_s)
  );
  logic csn_s, sclk_s, mosi_s, gpin_s;
  assign csn_s  = pin_s[3];
  assign sclk_s = pin_s[2];
  assign mosi_s = pin_s[1];
  assign gpin_s = pin_s[0];

  // registers
  logic [7:0] offs_q, chigh_q, cmid_q, clow_q, rexp_q, rmant_q, fmt_q;
  logic [7:0] offs_d, chigh_d, cmid_d, clow_d, rexp_d, rmant_d, fmt_d;

  // spi framing: header byte (r/w, burst, 6-bit address) then data bytes
  smcb_pkg::smcb_spi_t st_q, st_d;
  logic       sclk_d1_q;
  logic [2:0] bitc_q, bitc_d;
  logic [7:0] sh_q, sh_d;
  logic [5:0] addr_q, addr_d;
  logic       rd_q, rd_d, burst_q, burst_d;
  logic [7:0] tx_q, tx_d;
  logic       miso_q, miso_d;
  logic       rise, fall, byte_done, wr_stb;
  logic [7:0] byte_in, rd_data;

  assign rise      = sclk_s & ~sclk_d1_q;
  assign fall      = ~sclk_s & sclk_d1_q;
  assign byte_in   = {sh_q[6:0], mosi_s};
  assign byte_done = rise & ~csn_s & (bitc_q == 3'h7);
  assign wr_stb    = byte_done & (st_q == smcb_pkg::SMCB_SPI_DATA) & ~rd_q;

  // read mux
  assign rd_data =
    (addr_q == `SMCB_OFS_SYNTH_OFFSET) ? offs_q :
    (addr_q == `SMCB_OFS_CARRIER_HIGH) ? (chigh_q & `SMCB_CARRIER_HIGH_MASK) :
    (addr_q == `SMCB_OFS_CARRIER_MID)  ? cmid_q :
    (addr_q == `SMCB_OFS_CARRIER_LOW)  ? clow_q :
    (addr_q == `SMCB_OFS_RATE_EXP)     ? rexp_q :
    (addr_q == `SMCB_OFS_RATE_MANT)    ? rmant_q :
    (addr_q == `SMCB_OFS_FORMAT)       ? fmt_q : 8'h00;

  // spi sequencing
  always_comb begin
    st_d    = st_q;
    bitc_d  = bitc_q;
    sh_d    = sh_q;
    addr_d  = addr_q;
    rd_d    = rd_q;
    burst_d = burst_q;
    tx_d    = tx_q;
    miso_d  = miso_q;
    if (csn_s) begin
      st_d   = smcb_pkg::SMCB_SPI_CMD;
      bitc_d = 3'h0;
      miso_d = 1'b0;
    end else begin
      if (rise) begin
        sh_d   = byte_in;
        bitc_d = bitc_q + 3'h1;
      end
      if (fall) begin
        miso_d = tx_q[7];
        tx_d   = {tx_q[6:0], 1'b0};
      end
      if (byte_done) begin
        case (st_q)
          smcb_pkg::SMCB_SPI_CMD: begin
            rd_d    = byte_in[7];
            burst_d = byte_in[6];
            addr_d  = byte_in[5:0];
            st_d    = smcb_pkg::SMCB_SPI_DATA;
          end
          smcb_pkg::SMCB_SPI_DATA: begin
            if (burst_q) begin
              addr_d = addr_q + 6'h01;
            end
          end
          default: st_d = smcb_pkg::SMCB_SPI_CMD;
        endcase
      end
    end
  end

  // load read data once address is known
  logic load_tx_q;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      load_tx_q <= 1'b0;
    end else begin
      load_tx_q <= byte_done;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q      <= smcb_pkg::SMCB_SPI_CMD;
      sclk_d1_q <= 1'b0;
      bitc_q    <= 3'h0;
      sh_q      <= 8'h00;
      addr_q    <= 6'h00;
      rd_q      <= 1'b0;
      burst_q   <= 1'b0;
      tx_q      <= 8'h00;
      miso_q    <= 1'b0;
    end else begin
      st_q      <= st_d;
      sclk_d1_q <= sclk_s;
      bitc_q    <= bitc_d;
      sh_q      <= sh_d;
      addr_q    <= addr_d;
      rd_q      <= rd_d;
      burst_q   <= burst_d;
      tx_q      <= load_tx_q ? rd_data : tx_d;
      miso_q    <= miso_d;
    end
  end
  assign spi_miso    = miso_q;
  assign spi_miso_oe = ~csn_s;

  // register write decode
  logic [6:0] hit;
  assign hit[0] = wr_stb & (addr_q == `SMCB_OFS_SYNTH_OFFSET);
  assign hit[1] = wr_stb & (addr_q == `SMCB_OFS_CARRIER_HIGH);
  assign hit[2] = wr_stb & (addr_q == `SMCB_OFS_CARRIER_MID);
  assign hit[3] = wr_stb & (addr_q == `SMCB_OFS_CARRIER_LOW);
  assign hit[4] = wr_stb & (addr_q == `SMCB_OFS_RATE_EXP);
  assign hit[5] = wr_stb & (addr_q == `SMCB_OFS_RATE_MANT);
  assign hit[6] = wr_stb & (addr_q == `SMCB_OFS_FORMAT);
  assign offs_d  = hit[0] ? byte_in : offs_q;
  assign chigh_d = hit[1] ? (byte_in & `SMCB_CARRIER_HIGH_MASK) : chigh_q;
  assign cmid_d  = hit[2] ? byte_in : cmid_q;
  assign clow_d  = hit[3] ? byte_in : clow_q;
  assign rexp_d  = hit[4] ? byte_in : rexp_q;
  assign rmant_d = hit[5] ? byte_in : rmant_q;
  assign fmt_d   = hit[6] ? byte_in : fmt_q;

  // configuration registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      offs_q  <= `SMCB_RST_SYNTH_OFFSET;
      chigh_q <= `SMCB_RST_CARRIER_HIGH;
      cmid_q  <= `SMCB_RST_CARRIER_MID;
      clow_q  <= `SMCB_RST_CARRIER_LOW;
      rexp_q  <= `SMCB_RST_RATE_EXP;
      rmant_q <= `SMCB_RST_RATE_MANT;
      fmt_q   <= `SMCB_RST_FORMAT;
    end else begin
      offs_q  <= offs_d;
      chigh_q <= chigh_d;
      cmid_q  <= cmid_d;
      clow_q  <= clow_d;
      rexp_q  <= rexp_d;
      rmant_q <= rmant_d;
      fmt_q   <= fmt_d;
    end
  end

  // derived synthesizer and modem values
  logic [23:0] carrier_w, offs_ext, synth_n;
  logic [8:0]  mant9;
  logic [27:0] rate_n;
  logic [2:0]  mod_code, sync_code;
  smcb_pkg::smcb_mod_t  mod_n;
  smcb_pkg::smcb_sync_t sync_n;
  logic        async_src, manch_n, bit_n, rsvd_n;
  assign carrier_w = {chigh_q & `SMCB_CARRIER_HIGH_MASK, cmid_q, clow_q};
  assign offs_ext  = 24'({{14{offs_q[7]}}, offs_q, 2'b00});
  assign synth_n   = carrier_w + offs_ext;
  assign mant9     = `SMCB_RATE_IMPLIED | {1'b0, rmant_q};
  assign rate_n    = 28'({19'h0, mant9} << rexp_q[3:0]);
  assign mod_code  = fmt_q[6:4];
  assign sync_code = fmt_q[2:0];
  assign mod_n = (mod_code == 3'h0) ? smcb_pkg::SMCB_MOD_2FSK :
                 (mod_code == 3'h1) ? smcb_pkg::SMCB_MOD_GFSK :
                 (mod_code == 3'h3) ? smcb_pkg::SMCB_MOD_OOK :
                 (mod_code == 3'h4) ? smcb_pkg::SMCB_MOD_4FSK :
                 smcb_pkg::SMCB_MOD_RSVD;
  assign sync_n = (sync_code == 3'h0) ? smcb_pkg::SMCB_SYNC_NONE :
                  (sync_code == 3'h1) ? smcb_pkg::SMCB_SYNC_16 :
                  (sync_code == 3'h3) ? smcb_pkg::SMCB_SYNC_32 :
                  smcb_pkg::SMCB_SYNC_RSVD;
  assign async_src = (tx_data_source == `SMCB_SRC_ASYNC);
  assign manch_n   = fmt_q[`SMCB_MANCH_BIT] & ~async_src &
                     (mod_n != smcb_pkg::SMCB_MOD_4FSK);
  assign bit_n     = async_src ? gpin_s : fifo_tx_bit;
  assign rsvd_n    = (mod_n == smcb_pkg::SMCB_MOD_RSVD) |
                     (sync_n == smcb_pkg::SMCB_SYNC_RSVD);

  // registered outputs
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      synth_word           <= 24'h000000;
      base_carrier_word    <= 24'h000000;
      symbol_rate_step     <= 28'h0000000;
      symbol_rate_exponent <= 4'h0;
      symbol_rate_mantissa <= 8'h00;
      modulation_select    <= smcb_pkg::SMCB_MOD_2FSK;
      sync_length          <= smcb_pkg::SMCB_SYNC_NONE;
      manchester_on        <= 1'b0;
      tx_bit               <= 1'b0;
      cfg_reserved         <= 1'b0;
    end else begin
      synth_word           <= synth_n;
      base_carrier_word    <= carrier_w;
      symbol_rate_step     <= rate_n;
      symbol_rate_exponent <= rexp_q[3:0];
      symbol_rate_mantissa <= rmant_q;
      modulation_select    <= mod_n;
      sync_length          <= sync_n;
      manchester_on        <= manch_n;
      tx_bit               <= bit_n;
      cfg_reserved         <= rsvd_n;
    end
  end

  // checks
  AST_HIGH_BITS_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
    base_carrier_word[23:22] == 2'b00) else $error("carrier top bits set");
  AST_CARRIER_BYTES: assert property (@(posedge core_clk) disable iff (!rst_n)
    rst_n |=> base_carrier_word[15:0] == $past({cmid_q, clow_q})) else $error("carrier bytes");
  AST_SYNTH_SUM: assert property (@(posedge core_clk) disable iff (!rst_n)
    rst_n |=> synth_word ==
    24'(base_carrier_word + 24'({{14{$past(offs_q[7])}}, $past(offs_q), 2'b00})))
    else $error("synth sum");
  AST_RATE_MSB: assert property (@(posedge core_clk) disable iff (!rst_n)
    rst_n |=> symbol_rate_step[5'(symbol_rate_exponent) + 5'h08] == 1'b1)
    else $error("implied one");
  AST_RATE_VAL: assert property (@(posedge core_clk) disable iff (!rst_n)
    rst_n |=> symbol_rate_step ==
    ((28'h0000100 + 28'(symbol_rate_mantissa)) << symbol_rate_exponent))
    else $error("rate value");
  AST_EXP_LOW: assert property (@(posedge core_clk) disable iff (!rst_n)
    hit[4] |=> ##1 symbol_rate_exponent == $past(byte_in[3:0], 2)) else $error("exp");
  AST_MOD_OOK: assert property (@(posedge core_clk) disable iff (!rst_n)
    fmt_q[6:4] == 3'h3 |=> modulation_select == smcb_pkg::SMCB_MOD_OOK) else $error("ook");
  AST_MANCH_ASYNC: assert property (@(posedge core_clk) disable iff (!rst_n)
    async_src |=> !manchester_on) else $error("manchester async");
  AST_SYNC32: assert property (@(posedge core_clk) disable iff (!rst_n)
    fmt_q[2:0] == 3'h3 |=> sync_length == smcb_pkg::SMCB_SYNC_32) else $error("sync32");
  AST_ASYNC_PIN: assert property (@(posedge core_clk) disable iff (!rst_n)
    async_src |=> tx_bit == $past(gpin_s)) else $error("async pin");
  COV_WRITE: cover property (@(posedge core_clk) wr_stb);
  COV_4FSK: cover property (@(posedge core_clk) modulation_select == smcb_pkg::SMCB_MOD_4FSK);
  COV_RSVD: cover property (@(posedge core_clk) cfg_reserved);
endmodule

// file: tb/smcb_spi_host.sv
`timescale 1ns/1ns
// host side of the serial port: mode 0, msb first, header byte then data byte
module smcb_spi_host (
  input  wire logic core_clk,
  input  wire logic spi_miso,
  output logic      spi_csn_n,
  output logic      spi_sclk,
  output logic      spi_mosi
);
  int half = 8; // one less than the core cycles per serial half period, at least 4

  // idle: deselected, serial clock parked low
  initial begin
    spi_csn_n = 1'b1;
    spi_sclk  = 1'b0;
    spi_mosi  = 1'b0;
  end

  // one frame; read bits taken just before each rise, data bits land last
  task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
    @(posedge core_clk);
    spi_csn_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge core_clk);
      spi_sclk <= 1'b0;
      spi_mosi <= tx[i];
      repeat (half) @(posedge core_clk);
      @(negedge core_clk);
      rx[i % 8] = spi_miso;
      @(posedge core_clk);
      spi_sclk <= 1'b1;
      repeat (half) @(posedge core_clk);
    end
    @(posedge core_clk);
    spi_sclk <= 1'b0;
    repeat (half) @(posedge core_clk);
    spi_csn_n <= 1'b1;
    spi_mosi  <= ~spi_mosi; // released line must not show stale data
    repeat (half) @(posedge core_clk);
  endtask
endmodule

// file: tb/synth_modem_config_bank_bench.sv
`timescale 1ns/1ns
module synth_modem_config_bank_bench;
  logic                 core_clk, rst_n, spi_csn_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe;
  logic                 general_output_pin_zero, fifo_tx_bit, manchester_on, tx_bit, cfg_reserved;
  logic [1:0]           tx_data_source;
  logic [23:0]          synth_word, base_carrier_word;
  logic [27:0]          symbol_rate_step;
  logic [3:0]           symbol_rate_exponent;
  logic [7:0]           symbol_rate_mantissa, rd_val, wv;
  logic [15:0]          lfsr_q;
  logic [7:0]           shadow [7];
  smcb_pkg::smcb_mod_t  modulation_select;
  smcb_pkg::smcb_sync_t sync_length;
  int                   miscompares = 0, num_checks = 0, cycles = 0, k;

  // free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  smcb_bank smcb_bank_inst (.core_clk(core_clk), .rst_n(rst_n), .spi_csn_n(spi_csn_n),
    .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .tx_data_source(tx_data_source), .general_output_pin_zero(general_output_pin_zero),
    .fifo_tx_bit(fifo_tx_bit), .synth_word(synth_word), .base_carrier_word(base_carrier_word),
    .symbol_rate_step(symbol_rate_step), .symbol_rate_exponent(symbol_rate_exponent),
    .symbol_rate_mantissa(symbol_rate_mantissa), .modulation_select(modulation_select),
    .sync_length(sync_length), .manchester_on(manchester_on), .tx_bit(tx_bit),
    .cfg_reserved(cfg_reserved));
  smcb_spi_host smcb_spi_host_inst (.core_clk(core_clk), .spi_miso(spi_miso),
    .spi_csn_n(spi_csn_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi));

  // expectation helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic smcb_pkg::smcb_mod_t exp_mod(input logic [2:0] c);
    case (c)
      3'h0: return smcb_pkg::SMCB_MOD_2FSK;
      3'h1: return smcb_pkg::SMCB_MOD_GFSK;
      3'h3: return smcb_pkg::SMCB_MOD_OOK;
      3'h4: return smcb_pkg::SMCB_MOD_4FSK;
      default: return smcb_pkg::SMCB_MOD_RSVD;
    endcase
  endfunction
  function automatic smcb_pkg::smcb_sync_t exp_sync(input logic [2:0] c);
    case (c)
      3'h0: return smcb_pkg::SMCB_SYNC_NONE;
      3'h1: return smcb_pkg::SMCB_SYNC_16;
      3'h3: return smcb_pkg::SMCB_SYNC_32;
      default: return smcb_pkg::SMCB_SYNC_RSVD;
    endcase
  endfunction
  // host keeps to defined codes and keeps manchester apart from 4-fsk and async source
  function automatic logic [7:0] legal_fmt(input logic [7:0] v, input logic async);
    logic [2:0] m;
    m = v[5] ? (v[4] ? 3'h4 : 3'h3) : {1'b0, v[5:4]};
    return {v[7], m, v[3] & !async & (m != 3'h4), 1'b0, v[1], |v[1:0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    smcb_spi_host_inst.xfer({2'h2, a, 8'h00}, v);
  endtask
  task automatic wr(input int i, input logic [7:0] v);
    logic [7:0] d;
    smcb_spi_host_inst.xfer({2'h0, 6'h0C + 6'(i), v}, d);
    shadow[i] = (i == 1) ? (v & 8'h3F) : v;
  endtask
  // all configuration outputs against the shadow copy
  task automatic check_outputs;
    logic [2:0]  m;
    logic [23:0] cw;
    m = shadow[6][6:4];
    cw = {2'h0, shadow[1][5:0], shadow[2], shadow[3]};
    repeat (12) @(posedge core_clk);
    chk(base_carrier_word, cw);
    chk(synth_word, 24'(cw + {{14{shadow[0][7]}}, shadow[0], 2'h0}));
    chk(symbol_rate_step, {19'h0, 1'b1, shadow[5]} << shadow[4][3:0]);
    chk(symbol_rate_exponent, shadow[4][3:0]);
    chk(symbol_rate_mantissa, shadow[5]);
    chk(modulation_select, exp_mod(m));
    chk(sync_length, exp_sync(shadow[6][2:0]));
    chk(cfg_reserved, exp_mod(m) == smcb_pkg::SMCB_MOD_RSVD ||
        exp_sync(shadow[6][2:0]) == smcb_pkg::SMCB_SYNC_RSVD);
    chk(manchester_on, shadow[6][3] && m != 3'h4 && tx_data_source != 2'h3);
    chk(tx_bit, tx_data_source == 2'h3 ? general_output_pin_zero : fifo_tx_bit);
    chk(spi_miso_oe, 1'b0);
  endtask

  task automatic give_verdict;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    rst_n = 1'b0;
    tx_data_source = 2'h0;
    general_output_pin_zero = 1'b0;
    fifo_tx_bit = 1'b0;
    lfsr_q = 16'h1A03;
    shadow = '{8'h00, 8'h1E, 8'hC4, 8'hEC, 8'h8C, 8'h22, 8'h02};
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    // reset values, one unmapped place, outputs after reset
    for (int i = 0; i < 7; i++) begin
      rd(6'h0C + 6'(i), rd_val);
      chk(rd_val, shadow[i]);
    end
    rd(6'h13, rd_val);
    chk(rd_val, 8'h00);
    check_outputs();
    // top carrier bits stay clear; most negative offset
    wr(1, 8'hFF);
    rd(6'h0D, rd_val);
    chk(rd_val, 8'h3F);
    wr(0, 8'h80);
    check_outputs();
    // every modulation and sync code, manchester asked for except with 4-fsk
    for (int c = 0; c < 8; c++) begin
      wr(6, {1'b0, 3'(c), (c != 4), 3'(c)});
      check_outputs();
    end
    // random register traffic with random pin inputs and serial speed
    for (int n = 0; n < 30; n++) begin
      lfsr_q = lfsr_next(lfsr_q);
      tx_data_source <= (lfsr_q[0] && !shadow[6][3]) ? 2'h3 : 2'h0;
      general_output_pin_zero <= lfsr_q[1];
      fifo_tx_bit <= lfsr_q[2];
      smcb_spi_host_inst.half = lfsr_q[3] ? 16 : 8;
      k = int'(lfsr_q[6:4]) % 7;
      wv = (k == 6) ? legal_fmt(lfsr_q[15:8], lfsr_q[0]) : lfsr_q[15:8];
      wr(k, wv);
      check_outputs();
      rd(6'h0C + 6'(k), rd_val);
      chk(rd_val, shadow[k]);
    end
    give_verdict();
  end
endmodule
